// ==== logic/plld_lock_detector.sv ====
// Lock detector for the integer-N synthesizer: lock and unlock counters
`timescale 1ns/10ps
`default_nettype none

module plld_lock_detector (
  input wire logic core_clk, // Reference oscillator clock, 40 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic active, // Synthesizer active period
  input wire logic programmable_mode, // Programmable user mode selected
  input wire logic divider_reprog, // Pulse: divider ratios rewritten
  input wire plld_pkg::plld_pfd_t pfd, // Phase detector up/down pulses
  input wire plld_pkg::plld_cfg_t cfg, // Lock count, tolerance, hold select
  output logic lock_indicator, // Lock status
  output logic freq_select_one_lock_pin_o, // Shared pin output value
  output logic freq_select_one_lock_pin_oe_n, // Shared pin enable, low drives
  output logic [1:0] lock_state // Debug view of detector state
);
  import plld_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse classification

  logic up_s;
  logic dn_s;
  logic up_prev_q;
  logic dn_prev_q;
  logic up_prev_d;
  logic dn_prev_d;
  logic overlap;
  logic unbalanced;
  logic consecutive;

  // Only the phase detector pulses feed the decision
  assign up_s = pfd[PFD_UP_POS];
  assign dn_s = pfd[PFD_DN_POS];
  // Both pulses high together: loop near steady state
  assign overlap = up_s && dn_s;
  // One pulse without the other: start-up imbalance
  assign unbalanced = up_s ^ dn_s;
  // Up and down count as consecutive when they overlap or follow each
  // other within one clock; a lone pulse held longer breaks coherency
  assign consecutive = overlap || (up_s && dn_prev_q) || (dn_s && up_prev_q)
                     || (!up_s && !dn_s && !(up_prev_q ^ dn_prev_q));

  // Previous pulse levels
  always_comb begin
    up_prev_d = up_s;
    dn_prev_d = dn_s;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_prev_q <= 1'b0;
      dn_prev_q <= 1'b0;
    end else begin
      up_prev_q <= up_prev_d;
      dn_prev_q <= dn_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active period start detection

  logic active_q;
  logic active_d;
  logic restart;

  always_comb begin
    active_d = active;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  // Rising active or a new divider ratio restarts detection
  assign restart = (active && !active_q) || divider_reprog;

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  logic lock_reload;
  logic lock_count_en;
  logic lock_carry;
  logic err_reload;
  logic err_count_en;
  logic err_carry;
  logic unlock_evt;

  // Error carry in tracking mode is an unlock
  assign unlock_evt = err_carry && (cfg.lock_hold_select != HOLD_LATCHED);

  // Lock counter clocks only on overlap; imbalance leaves it frozen
  assign lock_count_en = overlap && !unbalanced && active;
  // Reload on unlock so the carry falls back
  assign lock_reload = restart || !active || unlock_evt;

  // Error counter is reloaded while pulses stay coherent
  assign err_reload = restart || !active || consecutive;
  // Otherwise it loses one count per reference clock
  assign err_count_en = active && !consecutive;

  // Lock counter: setting gives the number of decrements to carry
  plld_down_counter #(
    .W(LOCK_CNT_W),
    .RST_VAL(LOCK_CNT_RST)
  ) u_lock_counter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .reload(lock_reload),
    .start_val(cfg.lock_count_setting),
    .count_en(lock_count_en),
    .count(),
    .carry(lock_carry)
  );

  // Error counter: setting gives tolerated non-consecutive clocks
  plld_down_counter #(
    .W(ERR_CNT_W),
    .RST_VAL(ERR_CNT_RST)
  ) u_unlock_error_counter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .reload(err_reload),
    .start_val(cfg.unlock_tolerance_setting),
    .count_en(err_count_en),
    .count(),
    .carry(err_carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lock state machine

  plld_state_t state_q;
  plld_state_t state_d;
  logic lock_ind_q;
  logic lock_ind_d;

  // Latched mode holds lock until the active period ends or a divider reprogram restarts it; tracking
  // mode follows the counters so a slipping loop is reported
  always_comb begin
    state_d = state_q;
    case (state_q)
      PLLD_IDLE: begin
        if (active) begin
          state_d = PLLD_ACQUIRE;
        end
      end
      PLLD_ACQUIRE: begin
        if (lock_carry) begin
          if (cfg.lock_hold_select == HOLD_LATCHED) begin
            state_d = PLLD_HELD;
          end else begin
            state_d = PLLD_LOCKED;
          end
        end
      end
      PLLD_LOCKED: begin
        if (unlock_evt) begin
          state_d = PLLD_ACQUIRE;
        end
      end
      PLLD_HELD: begin
        state_d = PLLD_HELD;
      end
      default: begin
        state_d = PLLD_IDLE;
      end
    endcase
    if (!active || restart) begin
      state_d = active ? PLLD_ACQUIRE : PLLD_IDLE;
    end
    lock_ind_d = (state_d == PLLD_LOCKED) || (state_d == PLLD_HELD);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= PLLD_IDLE;
      lock_ind_q <= LOCK_IND_RST;
    end else begin
      state_q <= state_d;
      lock_ind_q <= lock_ind_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin: driven only in programmable mode, else it is a strap input

  logic pin_o_q;
  logic pin_o_d;
  logic pin_oe_n_q;
  logic pin_oe_n_d;

  always_comb begin
    pin_o_d = lock_ind_d;
    pin_oe_n_d = !programmable_mode;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_o_q <= LOCK_IND_RST;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  assign lock_indicator = lock_ind_q;
  assign freq_select_one_lock_pin_o = pin_o_q;
  assign freq_select_one_lock_pin_oe_n = pin_oe_n_q;
  assign lock_state = state_q;

endmodule : plld_lock_detector

`default_nettype wire

// ==== include/plld_pkg.sv ====
// Package: constants and carrier types of the synthesizer lock detector
package plld_pkg;

  // Counter widths; settings load directly into the counters
  localparam int LOCK_CNT_W = 8;
  localparam int ERR_CNT_W = 8;

  // Reset and start values
  localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_RST = 8'hFF;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_RST = 8'hFF;
  localparam logic LOCK_IND_RST = 1'b0;

  // Lock-hold select encoding
  localparam logic HOLD_LATCHED = 1'b0;

  // Field positions inside the phase detector carrier
  localparam int PFD_UP_POS = 0;
  localparam int PFD_DN_POS = 1;

  // Phase detector pulses, sampled in the reference clock domain
  typedef struct packed {
    logic dn;
    logic up;
  } plld_pfd_t;

  // Programmable settings
  typedef struct packed {
    logic [LOCK_CNT_W-1:0] lock_count_setting;
    logic [ERR_CNT_W-1:0] unlock_tolerance_setting;
    logic lock_hold_select;
  } plld_cfg_t;

  // Lock detector state
  typedef enum logic [1:0] {
    PLLD_IDLE,
    PLLD_ACQUIRE,
    PLLD_LOCKED,
    PLLD_HELD
  } plld_state_t;

endpackage : plld_pkg

// ==== logic/plld_down_counter.sv ====
// Reloadable down counter with carry, used for lock and unlock counting
`timescale 1ns/10ps
`default_nettype none

module plld_down_counter #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic core_clk, // Reference clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic reload, // Load start value, wins over count
  input wire logic [W-1:0] start_val, // Start value
  input wire logic count_en, // Decrement one step
  output logic [W-1:0] count, // Current count
  output logic carry // Counter has reached zero
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic carry_q;
  logic carry_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next value: reload first, then count down, stick at zero
  always_comb begin
    cnt_d = cnt_q;
    carry_d = carry_q;
    if (reload) begin
      cnt_d = start_val;
      carry_d = 1'b0;
    end else if (count_en && !carry_q) begin
      if (cnt_q <= W'(1)) begin
        cnt_d = '0;
        carry_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  // Registers; reset loads the caller's reset value with carry clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= RST_VAL;
      carry_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      carry_q <= carry_d;
    end
  end

  assign count = cnt_q;
  assign carry = carry_q;

endmodule : plld_down_counter

`default_nettype wire

// ==== verif/plld_checker.sv ====
// Checker: port timing of the lock detector
`timescale 1ns/10ps
`default_nettype none
module plld_checker
  import plld_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic active, // Active period
  input wire logic programmable_mode, // Mode
  input wire logic divider_reprog, // Reprogram
  input wire plld_pfd_t pfd, // Pulses
  input wire plld_cfg_t cfg, // Settings
  input wire logic lock_indicator, // Lock
  input wire logic freq_select_one_lock_pin_o, // Pin value
  input wire logic freq_select_one_lock_pin_oe_n // Pin enable
);
  logic [8:0] run_q;
  logic [8:0] run_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Lone up run while tracking; a bound, since the first lone pulse may still count as consecutive
  always_comb begin
    run_d = 9'h000;
    if (pfd == 2'h1 && lock_indicator && cfg.lock_hold_select != HOLD_LATCHED) begin
      run_d = run_q + 9'h001;
    end
  end
  // Register the run length
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 9'h000;
    end else begin
      run_q <= run_d;
    end
  end
  chk_pin_value: assert property (freq_select_one_lock_pin_o == lock_indicator)
    else $error("pin value differs from lock");
  chk_pin_enable: assert property (!$past(sys_rst) |->
    freq_select_one_lock_pin_oe_n == !$past(programmable_mode))
    else $error("pin enable wrong");
  chk_idle_clear: assert property (!active |=> !lock_indicator)
    else $error("lock while inactive");
  chk_reprog_clear: assert property (divider_reprog |=> !lock_indicator)
    else $error("lock after reprogram");
  chk_rise_cause: assert property ($rose(lock_indicator) |->
    $past(active) && !$past(divider_reprog))
    else $error("lock rose without cause");
  chk_rise_overlap: assert property ($rose(lock_indicator) |->
    $past(pfd.up && pfd.dn) || $past(pfd.up && pfd.dn, 2))
    else $error("lock rose without overlap");
  chk_latch_hold: assert property (
    lock_indicator && active && !divider_reprog && cfg.lock_hold_select == HOLD_LATCHED
    |=> lock_indicator)
    else $error("latched lock dropped");
  // Tolerance plus carry edge and state edge; a zero setting acts as one
  chk_unlock_bound: assert property (
    run_q <= {1'b0, cfg.unlock_tolerance_setting} + 9'h003)
    else $error("unlock too late");
endmodule : plld_checker
bind plld_lock_detector plld_checker u_plld_checker (.core_clk(core_clk), .sys_rst(sys_rst),
  .active(active), .programmable_mode(programmable_mode), .divider_reprog(divider_reprog),
  .pfd(pfd), .cfg(cfg), .lock_indicator(lock_indicator),
  .freq_select_one_lock_pin_o(freq_select_one_lock_pin_o),
  .freq_select_one_lock_pin_oe_n(freq_select_one_lock_pin_oe_n));
`default_nettype wire

// ==== verif/plld_pfd_model.sv ====
// Phase detector model: up and down pulse patterns
`timescale 1ns/10ps
`default_nettype none
module plld_pfd_model (
  input wire logic core_clk, // Reference clock
  input wire logic [1:0] mode, // 0 none, 1 overlap, 2 lone up, 3 lone down
  output var plld_pkg::plld_pfd_t pfd // Pulses
);
  // Change on the falling edge so the detector never samples a moving pulse;
  // one process owns the pulses, which start idle
  initial begin
    pfd = 2'h0;
    forever begin
      @(negedge core_clk);
      pfd <= '{dn: (mode == 2'h1) || (mode == 2'h3), up: (mode == 2'h1) || (mode == 2'h2)};
    end
  end
endmodule : plld_pfd_model
`default_nettype wire

// ==== verif/tb.sv ====
// Testbench of the lock detector
`timescale 1ns/10ps
`default_nettype none
module tb;
  import plld_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic active = 1'b0;
  logic programmable_mode = 1'b1;
  logic divider_reprog = 1'b0;
  logic [1:0] mode = 2'h0;
  plld_pfd_t pfd;
  plld_cfg_t cfg = '0;
  logic lock_ind;
  logic pin_o;
  logic oe_n;
  logic [1:0] lock_st;
  int n_fail = 0;
  int num_checks = 0;
  // Clock generation
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  plld_pfd_model u_plld_pfd_model (.core_clk(core_clk), .mode(mode), .pfd(pfd));
  plld_lock_detector u_plld_lock_detector (.core_clk(core_clk), .sys_rst(sys_rst),
    .active(active), .programmable_mode(programmable_mode), .divider_reprog(divider_reprog),
    .pfd(pfd), .cfg(cfg), .lock_indicator(lock_ind), .freq_select_one_lock_pin_o(pin_o),
    .freq_select_one_lock_pin_oe_n(oe_n), .lock_state(lock_st));
  task automatic chk(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // Model output lags the mode by one falling edge
  task automatic run(input logic [1:0] m, input int n);
    @(negedge core_clk);
    mode <= m;
    repeat (n) @(negedge core_clk);
  endtask : run
  task automatic t_lock(input logic [7:0] s, input logic [7:0] t, input logic h);
    @(negedge core_clk);
    cfg <= '{s, t, h};
    active <= 1'b0;
    run(2'h0, 3);
    chk(lock_ind, 1'b0);
    active <= 1'b1;
    run(2'h2, 30);
    chk(lock_ind, 1'b0);
    run(2'h1, int'(s) - 2);
    chk(lock_ind, 1'b0);
    run(2'h1, 6);
    chk(lock_ind, 1'b1);
    chk(pin_o, 1'b1);
    $display("lock test done");
  endtask : t_lock
  task automatic t_pin;
    programmable_mode <= 1'b0;
    run(2'h0, 2);
    chk(oe_n, 1'b1);
    programmable_mode <= 1'b1;
    run(2'h0, 2);
    chk(oe_n, 1'b0);
    $display("pin test done");
  endtask : t_pin
  task automatic t_latched;
    t_lock(8'h14, 8'h08, 1'b0);
    run(2'h2, 300);
    chk(lock_ind, 1'b1);
    chk(lock_st == PLLD_HELD, 1'b1);
    divider_reprog <= 1'b1;
    @(negedge core_clk);
    divider_reprog <= 1'b0;
    run(2'h0, 2);
    chk(lock_ind, 1'b0);
    chk(pin_o, 1'b0);
    chk(lock_st == PLLD_ACQUIRE, 1'b1);
    $display("latched test done");
  endtask : t_latched
  task automatic t_track;
    t_lock(8'h06, 8'h10, 1'b1);
    run(2'h1, 300);
    chk(lock_ind, 1'b1);
    chk(lock_st == PLLD_LOCKED, 1'b1);
    run(2'h3, 12);
    chk(lock_ind, 1'b1);
    run(2'h2, 14);
    chk(lock_ind, 1'b1);
    run(2'h2, 10);
    chk(lock_ind, 1'b0);
    run(2'h1, 4);
    chk(lock_ind, 1'b0);
    run(2'h1, 6);
    chk(lock_ind, 1'b1);
    $display("tracking test done");
  endtask : t_track
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Whole run is near 840 cycles; stop a hang well past that
  initial begin
    #(25 * 4000);
    n_fail++;
    results;
  end
  // Main sequence
  initial begin
    repeat (20) @(negedge core_clk);
    chk(oe_n, 1'b1);
    chk(lock_st == PLLD_IDLE, 1'b1);
    sys_rst <= 1'b0;
    t_pin;
    t_lock(8'h05, 8'h08, 1'b1);
    t_latched;
    t_track;
    results;
  end
endmodule : tb
`default_nettype wire
